// >>> src/cwp_map.vh
// Constants for the configuration word decoder: offsets, fields, counts.
// Assumes a 100 MHz ref_clk and an AHB-Lite register port at word offsets.
`ifndef CWP_MAP_VH
`define CWP_MAP_VH
// Offsets are register indices; the byte address is four times the index
`define CWP_OFF_UID0      32'h0000_8000
`define CWP_OFF_IDENT     32'h0000_8006
`define CWP_OFF_CFG1      32'h0000_8007
`define CWP_OFF_CFG2      32'h0000_8008
`define CWP_OFF_OSCCTL    32'h0000_8010
`define CWP_OFF_STATUS    32'h0000_8014
`define CWP_OFF_PROG      32'h0000_8018
`define CWP_CFG2_ONES     14'h08EC
`define CWP_B_LOWV_PROG   13
`define CWP_B_DBG         12
`define CWP_B_BO_LEVEL    10
`define CWP_B_STK         9
`define CWP_B_PLL         8
`define CWP_B_DATA_PROT   8
`define CWP_B_CODE_PROT   7
`define CWP_STARTUP_CYC   11'h400
`define CWP_OSEL_XTAL_LOW  3'h0
`define CWP_OSEL_XTAL_MED  3'h1
`define CWP_OSEL_XTAL_HIGH 3'h2
`define CWP_OSEL_RC        3'h3
`define CWP_OSEL_INT       3'h4
`define CWP_OSEL_EXT_LOW   3'h5
`define CWP_OSEL_EXT_MED   3'h6
`define CWP_OSEL_EXT_HIGH  3'h7
`endif

// >>> src/cwp_config_loader.v
// Configuration word decoder with protection and clock-mode selection.
// Assumes config words arrive on ports, AHB-Lite single word transfers.
`timescale 1ns/1ps
`default_nettype none
`include "cwp_map.vh"
module cwp_config_loader #(
  parameter [8:0] DEVICE_IDENT   = 9'h15B, // Arbitrary value
  parameter [4:0] REVISION_IDENT = 5'h01   // Arbitrary value
) (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [13:0] nv_cfg_word_one,
  input  wire [13:0] nv_cfg_word_two,
  input  wire        lv_entry_req,
  input  wire        hv_entry_req,
  input  wire        ext_prog_rd,
  input  wire        ext_prog_wr,
  input  wire        ext_data_rd,
  input  wire        ext_data_wr,
  input  wire [7:0]  ext_rd_data_in,
  input  wire        cpu_prog_wr,
  input  wire [12:0] cpu_prog_addr,
  input  wire        stack_fault,
  input  wire        osc_clock_tick,
  input  wire        ext_clock_lost,
  input  wire        wake_event,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         prog_mode_active,
  output reg         debug_pins_owned,
  output reg         brownout_low_trip,
  output reg         stack_reset_req,
  output reg         pll_enable,
  output reg         ext_prog_grant,
  output reg         ext_data_grant,
  output reg  [7:0]  ext_rd_data_out,
  output reg         cpu_prog_wr_grant,
  output reg  [2:0]  osc_mode,
  output reg  [1:0]  sys_clock_source,
  output reg  [1:0]  int_source_select,
  output reg         clock_pin_released,
  output reg         exec_hold
);

////////////////////////////////////////////////////////////////////////////
// Configuration latch and pin synchronisers

reg  [13:0] cfg1_q;
reg  [13:0] cfg2_q;
reg         cfg_loaded_q;
reg  [2:0]  tick_sync_q;
reg  [2:0]  lost_sync_q;
reg  [2:0]  wake_sync_q;
reg         tick_st_q;
reg         lost_st_q;
reg         wake_st_q;
reg  [13:0] prog_val;
reg         prog_we;

always @(posedge ref_clk) begin
  if (!resetn) begin
    cfg_loaded_q <= 1'b0;
    cfg1_q       <= 14'h3FFF;
    cfg2_q       <= 14'h3FFF;
  end else if (!cfg_loaded_q) begin
    // Caught once after release; until next reset only a PROG write changes word two
    cfg_loaded_q <= 1'b1;
    cfg1_q       <= nv_cfg_word_one;
    cfg2_q       <= nv_cfg_word_two | `CWP_CFG2_ONES;
  end else if (prog_we) begin
    cfg2_q <= prog_val | `CWP_CFG2_ONES;
  end
end

// Three flops; a change counts once the last two agree
always @(posedge ref_clk) begin
  if (!resetn) begin
    tick_sync_q <= 3'h0;
    lost_sync_q <= 3'h0;
    wake_sync_q <= 3'h0;
    tick_st_q   <= 1'b0;
    lost_st_q   <= 1'b0;
    wake_st_q   <= 1'b0;
  end else begin
    tick_sync_q <= {tick_sync_q[1:0], osc_clock_tick};
    lost_sync_q <= {lost_sync_q[1:0], ext_clock_lost};
    wake_sync_q <= {wake_sync_q[1:0], wake_event};
    if (tick_sync_q[1] == tick_sync_q[2])
      tick_st_q <= tick_sync_q[2];
    if (lost_sync_q[1] == lost_sync_q[2])
      lost_st_q <= lost_sync_q[2];
    if (wake_sync_q[1] == wake_sync_q[2])
      wake_st_q <= wake_sync_q[2];
  end
end

////////////////////////////////////////////////////////////////////////////
// AHB-Lite slave

reg         ph_valid_q;
reg         ph_write_q;
reg  [31:0] ph_addr_q;
reg  [13:0] uid_q [0:3];
reg  [1:0]  clk_sel_q;
reg  [1:0]  irc_q;
reg         lv_mode_q;
reg         refused_q;
reg  [31:0] rd_d;
wire [2:0]  osel = cfg1_q[2:0];
// Registers decode on the word index; byte lanes are not used
wire [31:0] reg_idx = {2'b00, ph_addr_q[31:2]};
wire        wr_go = ph_valid_q && ph_write_q;
wire        rd_take = hready && hsel && htrans[1] && !hwrite;

always @(posedge ref_clk) begin
  if (!resetn) begin
    ph_valid_q <= 1'b0;
    ph_write_q <= 1'b0;
    ph_addr_q  <= 32'h0000_0000;
    hreadyout  <= 1'b1;
    hresp      <= 1'b0;
    hrdata     <= 32'h0000_0000;
  end else begin
    // One wait state on reads: the word is fetched after any write
    // that lands in the same cycle as the read's address phase
    hreadyout <= !rd_take;
    hresp     <= 1'b0;
    if (hready) begin
      ph_valid_q <= hsel && htrans[1];
      ph_write_q <= hwrite;
      ph_addr_q  <= haddr;
    end
    if (ph_valid_q && !ph_write_q && !hreadyout)
      hrdata <= rd_d;
  end
end

// Word index decode; unmapped words read as zero
always @* begin
  rd_d = 32'h0000_0000;
  case (reg_idx)
    `CWP_OFF_UID0:        rd_d = {18'h0, uid_q[0]};
    `CWP_OFF_UID0 + 32'h1: rd_d = {18'h0, uid_q[1]};
    `CWP_OFF_UID0 + 32'h2: rd_d = {18'h0, uid_q[2]};
    `CWP_OFF_UID0 + 32'h3: rd_d = {18'h0, uid_q[3]};
    `CWP_OFF_IDENT: rd_d = {18'h0, DEVICE_IDENT, REVISION_IDENT};
    `CWP_OFF_CFG1:  rd_d = {18'h0, cfg1_q};
    `CWP_OFF_CFG2:  rd_d = {18'h0, cfg2_q};
    `CWP_OFF_OSCCTL: rd_d = {28'h0, irc_q, clk_sel_q};
    `CWP_OFF_STATUS: rd_d = {26'h0, refused_q, exec_hold, lv_mode_q,
                             sys_clock_source, lost_st_q};
    default:        rd_d = 32'h0000_0000;
  endcase
end

// Programming of word two through the protection path
always @* begin
  prog_we  = wr_go && (reg_idx == `CWP_OFF_PROG) && prog_mode_active;
  prog_val = hwdata[13:0];
  // Low-voltage entry may not clear its own enable bit
  if (lv_mode_q && !hwdata[`CWP_B_LOWV_PROG])
    prog_we = 1'b0;
end

genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_uid
    always @(posedge ref_clk) begin
      if (!resetn)
        uid_q[gi] <= 14'h3FFF;
      else if (wr_go && reg_idx == `CWP_OFF_UID0 + gi)
        uid_q[gi] <= hwdata[13:0];
    end
  end
endgenerate

always @(posedge ref_clk) begin
  if (!resetn) begin
    clk_sel_q <= 2'h0;
    irc_q     <= 2'h0;
    refused_q <= 1'b0;
  end else begin
    if (wr_go && reg_idx == `CWP_OFF_OSCCTL) begin
      clk_sel_q <= hwdata[1:0];
      irc_q     <= hwdata[3:2];
    end
    if (wr_go && reg_idx == `CWP_OFF_PROG && prog_mode_active
        && lv_mode_q && !hwdata[`CWP_B_LOWV_PROG])
      refused_q <= 1'b1;
    else if (wr_go && reg_idx == `CWP_OFF_STATUS && hwdata[5])
      refused_q <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// Programming entry, protection and control decode

always @(posedge ref_clk) begin
  if (!resetn) begin
    lv_mode_q        <= 1'b0;
    prog_mode_active <= 1'b0;
  end else if (!prog_mode_active && cfg_loaded_q) begin
    if (lv_entry_req && cfg2_q[`CWP_B_LOWV_PROG]) begin
      prog_mode_active <= 1'b1;
      lv_mode_q        <= 1'b1;
    end else if (hv_entry_req) begin
      prog_mode_active <= 1'b1;
    end
  end
end

always @(posedge ref_clk) begin
  if (!resetn) begin
    debug_pins_owned  <= 1'b0;
    brownout_low_trip <= 1'b1;
    stack_reset_req   <= 1'b0;
    pll_enable        <= 1'b0;
    ext_prog_grant    <= 1'b0;
    ext_data_grant    <= 1'b0;
    ext_rd_data_out   <= 8'h00;
    cpu_prog_wr_grant <= 1'b0;
  end else begin
    debug_pins_owned  <= !cfg2_q[`CWP_B_DBG];
    brownout_low_trip <= cfg2_q[`CWP_B_BO_LEVEL];
    stack_reset_req   <= stack_fault && cfg2_q[`CWP_B_STK];
    pll_enable        <= cfg2_q[`CWP_B_PLL];
    ext_prog_grant    <= (ext_prog_rd || ext_prog_wr)
                         && cfg1_q[`CWP_B_CODE_PROT];
    ext_data_grant    <= (ext_data_rd || ext_data_wr)
                         && cfg1_q[`CWP_B_DATA_PROT];
    ext_rd_data_out   <= cfg1_q[`CWP_B_CODE_PROT] ? ext_rd_data_in
                                                  : 8'h00;
    // CPU reads never gated; only the self-write field limits writes
    case (cfg2_q[1:0])
      2'h3:    cpu_prog_wr_grant <= cpu_prog_wr;
      2'h2:    cpu_prog_wr_grant <= cpu_prog_wr && cpu_prog_addr > 13'h01FF;
      2'h1:    cpu_prog_wr_grant <= cpu_prog_wr && cpu_prog_addr > 13'h0FFF;
      default: cpu_prog_wr_grant <= 1'b0;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// Clock mode, start-up timer and failure switchover

localparam [1:0] ST_LOAD = 2'h0;
localparam [1:0] ST_WAIT = 2'h1;
localparam [1:0] ST_RUN  = 2'h2;
reg  [1:0]  state_q;
reg  [10:0] start_cnt_q;
reg         tick_prev_q;
reg         wake_prev_q;
reg         failed_q;
wire        crystal = (osel == `CWP_OSEL_XTAL_LOW)
                      || (osel == `CWP_OSEL_XTAL_MED)
                      || (osel == `CWP_OSEL_XTAL_HIGH);
wire        tick_edge = tick_st_q && !tick_prev_q;

always @(posedge ref_clk) begin
  if (!resetn) begin
    state_q     <= ST_LOAD;
    start_cnt_q <= 11'h000;
    tick_prev_q <= 1'b0;
    wake_prev_q <= 1'b0;
    failed_q    <= 1'b0;
    exec_hold   <= 1'b1;
  end else begin
    tick_prev_q <= tick_st_q;
    wake_prev_q <= wake_st_q;
    if (lost_st_q && osel != `CWP_OSEL_INT)
      failed_q <= 1'b1;
    case (state_q)
      ST_LOAD: begin
        if (cfg_loaded_q) begin
          start_cnt_q <= 11'h000;
          state_q <= crystal ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (tick_edge)
          start_cnt_q <= start_cnt_q + 11'h001;
        if (start_cnt_q == `CWP_STARTUP_CYC || failed_q) begin
          state_q   <= ST_RUN;
          exec_hold <= 1'b0;
        end
      end
      ST_RUN: begin
        exec_hold <= 1'b0;
        if (wake_st_q && !wake_prev_q && crystal) begin
          start_cnt_q <= 11'h000;
          exec_hold   <= 1'b1;
          state_q   <= ST_WAIT;
        end
      end
      default: state_q <= ST_LOAD;
    endcase
  end
end

// Fully static: state moves only on clock edges, never on time
always @(posedge ref_clk) begin
  if (!resetn) begin
    osc_mode           <= `CWP_OSEL_INT;
    sys_clock_source   <= 2'h0;
    int_source_select  <= 2'h0;
    clock_pin_released <= 1'b0;
  end else begin
    osc_mode           <= osel;
    clock_pin_released <= (osel == `CWP_OSEL_INT);
    int_source_select  <= irc_q;
    if (failed_q)
      sys_clock_source <= 2'h2;
    else
      sys_clock_source <= clk_sel_q[1] ? 2'h2 : clk_sel_q;
  end
end

endmodule // cwp_config_loader
`default_nettype wire

// >>> testbench/cwp_prog_partner.sv
// Programmer and debugger model on the external access pins.
// Assumes the bench steers it with a command word each cycle.
`timescale 1ns/1ps
`default_nettype none
module cwp_prog_partner (
  input  wire logic       ref_clk,
  input  wire logic [5:0] cmd,
  output logic            lv_entry_req,
  output logic            hv_entry_req,
  output logic            ext_prog_rd,
  output logic            ext_prog_wr,
  output logic            ext_data_rd,
  output logic            ext_data_wr,
  output logic      [7:0] ext_rd_data_in
);
  localparam logic [7:0] MEM_BYTE = 8'h5A;
  initial {lv_entry_req, hv_entry_req, ext_rd_data_in} = 10'h000;
  initial {ext_prog_rd, ext_prog_wr, ext_data_rd, ext_data_wr} = 4'h0;
  always @(posedge ref_clk) begin
    {hv_entry_req, lv_entry_req} <= cmd[5:4];
    {ext_data_wr, ext_data_rd, ext_prog_wr, ext_prog_rd} <= cmd[3:0];
    // Idle bus toggles so a stale byte never holds for two cycles in a row
    ext_rd_data_in <= cmd[0] ? MEM_BYTE : ~ext_rd_data_in;
  end
endmodule // cwp_prog_partner
`default_nettype wire

// >>> testbench/cwp_config_properties.sv
// Checker bound to the configuration decoder ports.
// Assumes words latch on the first edge after resetn rises.
`timescale 1ns/1ps
`default_nettype none
module cwp_config_checker (
  input wire        ref_clk,
  input wire        resetn,
  input wire [13:0] nv_cfg_word_one,
  input wire [13:0] nv_cfg_word_two,
  input wire        stack_fault,
  input wire        cpu_prog_wr,
  input wire [12:0] cpu_prog_addr,
  input wire        pll_enable,
  input wire        brownout_low_trip,
  input wire        debug_pins_owned,
  input wire        stack_reset_req,
  input wire [7:0]  ext_rd_data_out,
  input wire        ext_prog_grant,
  input wire        ext_data_grant,
  input wire        cpu_prog_wr_grant,
  input wire        clock_pin_released
);
  reg  [1:0]  up_q;
  reg  [13:0] c1_q;
  reg  [13:0] c2_q;
  // Outputs lag the latch by one edge, so checks start on the fourth
  wire        ok = up_q == 2'h3;
  wire [1:0]  wp = c2_q[1:0];
  wire        prot = wp == 2'h0 || (wp == 2'h1 && cpu_prog_addr < 13'h1000)
    || (wp == 2'h2 && cpu_prog_addr < 13'h0200);
  always @(posedge ref_clk) begin
    if (!resetn)
      up_q <= 2'h0;
    else if (!ok)
      up_q <= up_q + 2'h1;
  end
  always @(posedge ref_clk) begin
    if (resetn && up_q == 2'h0) begin
      c1_q <= nv_cfg_word_one;
      c2_q <= nv_cfg_word_two;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_pll_follow:
    assert property (ok |-> pll_enable == c2_q[8])
    else $error("pll enable wrong");
  a_trip_sel:
    assert property (ok |-> brownout_low_trip == c2_q[10])
    else $error("trip select wrong");
  a_debug_own:
    assert property (ok |-> debug_pins_owned == !c2_q[12])
    else $error("debug ownership wrong");
  a_stack_reset:
    assert property (ok |=> stack_reset_req == ($past(stack_fault) && c2_q[9]))
    else $error("stack reset wrong");
  a_prog_guard:
    assert property (ok && !c1_q[7] |-> ext_rd_data_out == 8'h00
      && !ext_prog_grant)
    else $error("program memory exposed");
  a_data_guard:
    assert property (ok && !c1_q[8] |-> !ext_data_grant)
    else $error("data memory exposed");
  a_pin_free:
    assert property (ok |-> clock_pin_released == (c1_q[2:0] == 3'h4))
    else $error("clock pin release wrong");
  a_self_write:
    assert property (ok |=> cpu_prog_wr_grant == ($past(cpu_prog_wr)
      && !$past(prot)))
    else $error("self write grant wrong");
  c_stack: cover property (stack_reset_req);
  c_denied: cover property (cpu_prog_wr && prot);
  c_ext_read: cover property (ext_prog_grant);
endmodule // cwp_config_checker
bind cwp_config_loader cwp_config_checker u_chk (.ref_clk, .resetn,
  .nv_cfg_word_one, .nv_cfg_word_two, .stack_fault, .cpu_prog_wr,
  .cpu_prog_addr, .pll_enable, .brownout_low_trip, .debug_pins_owned,
  .stack_reset_req, .ext_rd_data_out, .ext_prog_grant, .ext_data_grant,
  .cpu_prog_wr_grant, .clock_pin_released);
`default_nettype wire

// >>> testbench/tb_config_word_protect_clock_select.sv
// Self-checking bench for the configuration decoder and its register port.
// Assumes the programmer model on the external pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "cwp_map.vh"
module tb_config_word_protect_clock_select;
  logic        ref_clk = 1'b0, resetn = 1'b0, stack_fault = 1'b0;
  logic        cpu_prog_wr = 1'b0, osc_clock_tick = 1'b0, hwrite = 1'b0;
  logic        ext_clock_lost = 1'b0, wake_event = 1'b0, hsel = 1'b0;
  logic [13:0] nv_cfg_word_one = 14'h3FFF, nv_cfg_word_two = 14'h3FFF;
  logic [13:0] w1, w2;
  logic [3:0]  e;
  logic [12:0] cpu_prog_addr = 13'h0000;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [5:0]  cmd = 6'h00;
  wire  [31:0] hrdata;
  wire  [7:0]  ext_rd_data_in, ext_rd_data_out;
  wire  [2:0]  osc_mode;
  wire  [1:0]  sys_clock_source, int_source_select;
  wire         hreadyout, hresp, prog_mode_active, debug_pins_owned;
  wire         brownout_low_trip, stack_reset_req, pll_enable, exec_hold;
  wire         ext_prog_grant, ext_data_grant, cpu_prog_wr_grant;
  wire         clock_pin_released, lv_entry_req, hv_entry_req;
  wire         ext_prog_rd, ext_prog_wr, ext_data_rd, ext_data_wr;
  int          failures = 0, checked = 0, cyc = 0;
  logic [12:0] adr [4] = '{13'h01FF, 13'h0200, 13'h0FFF, 13'h1000};
  // Word one, word two, then pll, low trip, debug owned, pin released
  logic [31:0] rows [8] = '{
    {14'h3FF8, 14'h3FFF, 4'hC}, {14'h3FF9, 14'h3EFE, 4'h4},
    {14'h3FFA, 14'h3BFD, 4'h8}, {14'h3FFB, 14'h2FFF, 4'hE},
    {14'h3FFC, 14'h3FFF, 4'hD}, {14'h3F7D, 14'h3DFF, 4'hC},
    {14'h3EFE, 14'h3FFF, 4'hC}, {14'h3FFF, 14'h3FFC, 4'hC}};
  // Identity values are arbitrary
  cwp_config_loader #(.DEVICE_IDENT(9'h0C3), .REVISION_IDENT(5'h06)) DUT (
    .ref_clk, .resetn, .nv_cfg_word_one, .nv_cfg_word_two, .lv_entry_req,
    .hv_entry_req, .ext_prog_rd, .ext_prog_wr, .ext_data_rd, .ext_data_wr,
    .ext_rd_data_in, .cpu_prog_wr, .cpu_prog_addr, .stack_fault,
    .osc_clock_tick, .ext_clock_lost, .wake_event, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .prog_mode_active, .debug_pins_owned, .brownout_low_trip,
    .stack_reset_req, .pll_enable, .ext_prog_grant, .ext_data_grant,
    .ext_rd_data_out, .cpu_prog_wr_grant, .osc_mode, .sys_clock_source,
    .int_source_select, .clock_pin_released, .exec_hold);
  cwp_prog_partner u_prog (.ref_clk, .cmd, .lv_entry_req, .hv_entry_req,
    .ext_prog_rd, .ext_prog_wr, .ext_data_rd, .ext_data_wr, .ext_rd_data_in);
  always #5 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge ref_clk) {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a << 2};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic boot(input logic [13:0] a, b);
    @(posedge ref_clk) {resetn, nv_cfg_word_one, nv_cfg_word_two} <= {1'b0, a, b};
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    wt(4);
  endtask
  task automatic pulse;
    @(posedge ref_clk) osc_clock_tick <= 1'b1;
    repeat (2) @(posedge ref_clk);
    osc_clock_tick <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (rows[i]) begin
      {w1, w2, e} = rows[i];
      boot(w1, w2);
      chk({pll_enable, brownout_low_trip, debug_pins_owned,
        clock_pin_released}, e);
      chk(osc_mode, w1[2:0]);
      ahb(1'b0, `CWP_OFF_CFG2, 32'h0);
      chk(rd, {18'h0, w2 | 14'h08EC});
      @(posedge ref_clk) {stack_fault, cmd} <= {1'b1, 6'h0F};
      @(posedge ref_clk) stack_fault <= 1'b0;
      #1 chk(stack_reset_req, w2[9]);
      wt(1);
      chk({ext_prog_grant, ext_data_grant, ext_rd_data_out},
        {w1[7], w1[8], w1[7] ? 8'h5A : 8'h00});
      foreach (adr[j]) begin
        @(posedge ref_clk) {cpu_prog_wr, cpu_prog_addr} <= {1'b1, adr[j]};
        wt(1);
        chk(cpu_prog_wr_grant, w2[1:0] == 2'h3 || (w2[1:0] == 2'h2 &&
          adr[j] > 13'h01FF) || (w2[1:0] == 2'h1 && adr[j] > 13'h0FFF));
      end
      @(posedge ref_clk) {cmd, cpu_prog_wr} <= 7'h00;
      $display("test row %0d done", i);
    end
    @(posedge ref_clk) nv_cfg_word_two <= 14'h0000;
    wt(4);
    chk({pll_enable, brownout_low_trip}, 2'h3);
    for (int k = 0; k < 4; k++) begin
      ahb(1'b1, `CWP_OFF_OSCCTL, {28'h0, k[1:0], k[1:0]});
      wt(3);
      chk({int_source_select, sys_clock_source},
        {k[1:0], k[1] ? 2'h2 : k[1:0]});
    end
    @(posedge ref_clk) ext_clock_lost <= 1'b1;
    wt(8);
    chk(sys_clock_source, 2'h2);
    @(posedge ref_clk) ext_clock_lost <= 1'b0;
    ahb(1'b1, `CWP_OFF_UID0, 32'h1234);
    ahb(1'b0, `CWP_OFF_UID0, 32'h0);
    chk(rd, 32'h1234);
    ahb(1'b1, `CWP_OFF_IDENT, 32'h0);
    ahb(1'b0, `CWP_OFF_IDENT, 32'h0);
    chk(rd, 32'h1866);
    ahb(1'b0, 32'h9000, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    @(posedge ref_clk) cmd <= 6'h10;
    wt(4);
    chk(prog_mode_active, 1'b1);
    ahb(1'b1, `CWP_OFF_PROG, 32'h1FFF);
    ahb(1'b0, `CWP_OFF_STATUS, 32'h0);
    chk(rd[5], 1'b1);
    $display("test run-time cases done");
    // Low-voltage request stays up across this boot and must be ignored
    boot(14'h3FFF, 14'h1FFF);
    chk(prog_mode_active, 1'b0);
    @(posedge ref_clk) cmd <= 6'h20;
    wt(4);
    chk(prog_mode_active, 1'b1);
    @(posedge ref_clk) {cmd, resetn} <= 7'h00;
    wt(2);
    chk({exec_hold, osc_mode, brownout_low_trip}, 5'h19);
    $display("test entry and reset done");
    boot(14'h3FF8, 14'h3FFF);
    repeat (1023) pulse();
    wt(4);
    chk(exec_hold, 1'b1);
    pulse();
    wt(8);
    chk(exec_hold, 1'b0);
    $display("test start-up timer done");
    stop_test();
  end
endmodule // tb_config_word_protect_clock_select
`default_nettype wire
